// ===== design/mbd_pkg.sv
// Purpose: Shared constants for the processor bus glue (decode, clocking, strobe)
// Assumes: 250 MHz system clock; 15-bit processor address bus
// Notes: Times are kept in their own units; cycle counts derive from them
package mbd_pkg;

    // ************************************************************
    // Bus widths
    // ************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int LOW_ADDR_W = 11;
    // Synchroniser idle image: read/write high, all other pins low
    localparam logic [ADDR_W+4:0] PIN_IDLE = {{ADDR_W{1'b0}}, 5'h10};

    // ************************************************************
    // Select vector bit positions
    // ************************************************************
    localparam int SEL_RAM = 0;
    localparam int SEL_DIAG = 1;
    localparam int SEL_ROM2 = 2;
    localparam int SEL_TLTR = 3;
    localparam int SEL_MEMC = 4;
    localparam int SEL_PLUG = 5;
    localparam int SEL_IRQC = 6;
    localparam int SEL_INST = 7;
    localparam int SEL_CHAR = 8;
    localparam int SEL_ROM6 = 9;
    localparam int SEL_ROM7 = 10;
    localparam int SEL_N = 11;

    // ************************************************************
    // Region bases: address bits 14..12, and 11..10 inside 3xxx
    // ************************************************************
    localparam logic [2:0] BLK_RAM = 3'h0;
    localparam logic [2:0] BLK_DIAG = 3'h1;
    localparam logic [2:0] BLK_ROM2 = 3'h2;
    localparam logic [2:0] BLK_PERI = 3'h3;
    localparam logic [2:0] BLK_INST = 3'h4;
    localparam logic [2:0] BLK_CHAR = 3'h5;
    localparam logic [2:0] BLK_ROM6 = 3'h6;
    localparam logic [2:0] BLK_ROM7 = 3'h7;
    localparam logic [1:0] SUB_TLTR = 2'h0;
    localparam logic [1:0] SUB_MEMC = 2'h1;
    localparam logic [1:0] SUB_PLUG = 2'h2;
    localparam logic [1:0] SUB_IRQC = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_MHZ = 250;
    localparam int PULSE_DELAY_NS = 250;
    localparam int PULSE_WIDTH_NS = 100;
    localparam int RST_DELAY_US = 100;
    localparam int PULSE_DELAY_CYC = (PULSE_DELAY_NS * SYS_CLK_MHZ) / 1000;
    localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int RST_DELAY_CYC = RST_DELAY_US * SYS_CLK_MHZ;
    localparam int CNT_W = 16;

    // ************************************************************
    // Strobe timer states
    // ************************************************************
    typedef enum logic [2:0] {
        MBD_PULSE_IDLE = 3'h1,
        MBD_PULSE_WAIT = 3'h2,
        MBD_PULSE_HIGH = 3'h4
    } mbd_pulse_state_t;

    // ************************************************************
    // Reset sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        MBD_RST_HOLD = 3'h1,
        MBD_RST_TIME = 3'h2,
        MBD_RST_RUN = 3'h4
    } mbd_rst_state_t;

endpackage : mbd_pkg

// ===== design/mbd_div3.sv
// Purpose: Divide-by-three processor clock from board clock edges
// Assumes: board_edge_i is a one-cycle pulse per board clock rising edge
// Notes: Models two J-K stages clocked together
`timescale 1ns/1ps
`default_nettype none
module mbd_div3
    import mbd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic board_edge_i,
    output logic cpu_clk_o
);
    logic qa;
    logic qb;
    logic next_qa;
    logic next_qb;

    // ************************************************************
    // J-K next state, both J high
    // ************************************************************
    always_comb begin
        next_qa = qa;
        next_qb = qb;
        if (board_edge_i) begin
            next_qa = ~qa | ~qb;   // Ka follows Qb
            next_qb = ~qb | qa;    // Kb is Qa inverted
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            qa <= 1'b1;
            qb <= 1'b0;
        end else begin
            qa <= next_qa;
            qb <= next_qb;
        end
    end

    assign cpu_clk_o = qb;  // Three board edges per period
endmodule : mbd_div3
`default_nettype wire

// ===== design/mbd_strobe.sv
// Purpose: Mid-period strobe generator timed from phase-two rise
// Assumes: rise_i is a one-cycle pulse at each phase-two rising edge
// Notes: Delay then fixed-width pulse, both in system clock cycles
`timescale 1ns/1ps
`default_nettype none
module mbd_strobe
    import mbd_pkg::*;
#(
    parameter int DELAY_CYC = PULSE_DELAY_CYC,
    parameter int WIDTH_CYC = PULSE_WIDTH_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic rise_i,
    output logic strobe_o
);
    mbd_pulse_state_t state;
    mbd_pulse_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_strobe;

    // ************************************************************
    // Timer
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_strobe = 1'b0;
        case (state)
            MBD_PULSE_IDLE: begin
                if (rise_i) begin
                    next_state = MBD_PULSE_WAIT;
                    next_cnt = CNT_W'(DELAY_CYC - 1);
                end
            end
            MBD_PULSE_WAIT: begin
                if (cnt == '0) begin
                    next_state = MBD_PULSE_HIGH;
                    next_cnt = CNT_W'(WIDTH_CYC - 1);
                    next_strobe = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            MBD_PULSE_HIGH: begin
                if (cnt == '0) begin
                    next_state = MBD_PULSE_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                    next_strobe = 1'b1;           // Fixed width
                end
            end
            default: begin
                next_state = MBD_PULSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= MBD_PULSE_IDLE;
            cnt <= '0;
            strobe_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            strobe_o <= next_strobe;
        end
    end
endmodule : mbd_strobe
`default_nettype wire

// ===== design/mbd_top.sv
// Purpose: Processor bus glue: clock divider, reset, select decode, strobe, buffer control
// Assumes: All processor and board inputs are asynchronous pins
// Notes: Every output is registered; selects are one-hot or all low
`timescale 1ns/1ps
`default_nettype none
module mbd_top
    import mbd_pkg::*;
#(
    parameter int RESET_DELAY_CYC = RST_DELAY_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic board_clk_i,
    input wire logic power_good_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rw_i,
    input wire logic valid_address_flag_i,
    input wire logic phase_two_i,
    output logic cpu_clk_o,
    output logic reset_out_low_o,
    output logic [ADDR_W-1:0] sys_addr_o,
    output logic write_low_o,
    output logic mid_cycle_pulse_o,
    output logic addr_buf_en_o,
    output logic data_buf_to_bus_o,
    output logic data_buf_en_o,
    output logic scratch_memory_select_o,
    output logic diag_rom_select_o,
    output logic rom_two_select_o,
    output logic translator_select_o,
    output logic mem_ctrl_select_o,
    output logic plugin_bus_select_o,
    output logic irq_ctrl_select_o,
    output logic instrument_bus_select_o,
    output logic char_gen_select_o,
    output logic rom_six_select_o,
    output logic rom_seven_select_o
);
    // ************************************************************
    // Decode function
    // ************************************************************
    function automatic logic [SEL_N-1:0] region_sel(input logic [ADDR_W-1:0] a);
        logic [SEL_N-1:0] s;
        s = '0;
        case (a[14:12])
            BLK_RAM: s[SEL_RAM] = 1'b1;
            BLK_DIAG: s[SEL_DIAG] = 1'b1;
            BLK_ROM2: s[SEL_ROM2] = 1'b1;
            BLK_PERI: begin
                case (a[11:10])
                    SUB_TLTR: s[SEL_TLTR] = 1'b1;
                    SUB_MEMC: s[SEL_MEMC] = 1'b1;
                    SUB_PLUG: s[SEL_PLUG] = 1'b1;
                    SUB_IRQC: s[SEL_IRQC] = 1'b1;
                    default: s = '0;
                endcase
            end
            BLK_INST: s[SEL_INST] = 1'b1;
            BLK_CHAR: s[SEL_CHAR] = 1'b1;
            BLK_ROM6: s[SEL_ROM6] = 1'b1;
            BLK_ROM7: s[SEL_ROM7] = 1'b1;
            default: s = '0;
        endcase
        return s;
    endfunction : region_sel

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [ADDR_W+4:0] pin_meta;
    logic [ADDR_W+4:0] pin_sync;
    logic [ADDR_W+4:0] next_pin_meta;
    logic [ADDR_W-1:0] addr_s;
    logic rw_s;
    logic valid_s;
    logic e_s;
    logic bclk_s;
    logic pg_s;
    logic e_d;
    logic bclk_d;
    logic next_e_d;
    logic next_bclk_d;

    always_comb begin
        next_pin_meta = {addr_i, rw_i, valid_address_flag_i, phase_two_i, board_clk_i, power_good_i};
        next_e_d = e_s;
        next_bclk_d = bclk_s;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Idle image, so no false write strobe leaves reset
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            e_d <= 1'b0;
            bclk_d <= 1'b0;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= pin_meta;
            e_d <= next_e_d;
            bclk_d <= next_bclk_d;
        end
    end

    assign {addr_s, rw_s, valid_s, e_s, bclk_s, pg_s} = pin_sync;

    // ************************************************************
    // Clock divider and strobe
    // ************************************************************
    // The processor itself makes phase two by dividing this clock by four.
    mbd_div3 u_div3 (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .board_edge_i(bclk_s & ~bclk_d),
        .cpu_clk_o(cpu_clk_o)
    );

    mbd_strobe u_strobe (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .rise_i(e_s & ~e_d),                   // Timed from phase-two rise
        .strobe_o(mid_cycle_pulse_o)
    );

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    mbd_rst_state_t rst_state;
    mbd_rst_state_t next_rst_state;
    logic [CNT_W+1:0] rst_cnt;
    logic [CNT_W+1:0] next_rst_cnt;
    logic next_reset_out;

    always_comb begin
        next_rst_state = rst_state;
        next_rst_cnt = rst_cnt;
        next_reset_out = 1'b0;
        case (rst_state)
            MBD_RST_HOLD: begin
                if (pg_s) begin
                    next_rst_state = MBD_RST_TIME;
                    next_rst_cnt = (CNT_W+2)'(RESET_DELAY_CYC - 1);
                end
            end
            MBD_RST_TIME: begin
                if (!pg_s) begin
                    next_rst_state = MBD_RST_HOLD;
                end else if (rst_cnt == '0) begin
                    next_rst_state = MBD_RST_RUN;
                    next_reset_out = 1'b1;
                end else begin
                    next_rst_cnt = rst_cnt - 1'b1;
                end
            end
            MBD_RST_RUN: begin
                // Loss of power good drops reset at once
                if (!pg_s) begin
                    next_rst_state = MBD_RST_HOLD;
                end else begin
                    next_reset_out = 1'b1;
                end
            end
            default: begin
                next_rst_state = MBD_RST_HOLD;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_state <= MBD_RST_HOLD;
            rst_cnt <= '0;
            reset_out_low_o <= 1'b0;
        end else begin
            rst_state <= next_rst_state;
            rst_cnt <= next_rst_cnt;
            reset_out_low_o <= next_reset_out;
        end
    end

    // ************************************************************
    // Select decode and buffer control
    // ************************************************************
    logic dec_en;
    logic [SEL_N-1:0] sel;
    logic [SEL_N-1:0] next_sel;
    logic next_write_low;
    logic next_to_bus;
    logic next_buf_en;

    always_comb begin
        dec_en = valid_s & reset_out_low_o & e_s;
        next_sel = dec_en ? region_sel(addr_s) : '0;
        next_write_low = rw_s;
        next_to_bus = ~rw_s;
        // On-side devices answer directly, so the buffer must not fight them.
        next_buf_en = ~(next_sel[SEL_RAM] | next_sel[SEL_DIAG] | next_sel[SEL_ROM2]
                      | next_sel[SEL_ROM6] | next_sel[SEL_ROM7] | next_sel[SEL_PLUG]);
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel <= '0;
            sys_addr_o <= '0;
            write_low_o <= 1'b1;
            data_buf_to_bus_o <= 1'b0;
            data_buf_en_o <= 1'b1;
            addr_buf_en_o <= 1'b1;
        end else begin
            sel <= next_sel;
            sys_addr_o <= addr_s;
            write_low_o <= next_write_low;
            data_buf_to_bus_o <= next_to_bus;
            data_buf_en_o <= next_buf_en;
            addr_buf_en_o <= 1'b1;
        end
    end

    assign scratch_memory_select_o = sel[SEL_RAM];
    assign diag_rom_select_o = sel[SEL_DIAG];
    assign rom_two_select_o = sel[SEL_ROM2];
    assign translator_select_o = sel[SEL_TLTR];
    assign mem_ctrl_select_o = sel[SEL_MEMC];
    assign plugin_bus_select_o = sel[SEL_PLUG];
    assign irq_ctrl_select_o = sel[SEL_IRQC];
    assign instrument_bus_select_o = sel[SEL_INST];
    assign char_gen_select_o = sel[SEL_CHAR];
    assign rom_six_select_o = sel[SEL_ROM6];
    assign rom_seven_select_o = sel[SEL_ROM7];
endmodule : mbd_top
`default_nettype wire

// ===== verification/mbd_top_asserts.sv
// Purpose: Property checks on the bus glue outputs
// Assumes: One clock domain, nrst_i asynchronous active low
// Notes: Selects and sys_addr_o share the same pipeline depth
`timescale 1ns/1ps
`default_nettype none
module mbd_top_chk
    import mbd_pkg::*;
#(
    parameter int RESET_DELAY_CYC = RST_DELAY_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic reset_out_low_o,
    input wire logic [ADDR_W-1:0] sys_addr_o,
    input wire logic write_low_o,
    input wire logic mid_cycle_pulse_o,
    input wire logic addr_buf_en_o,
    input wire logic data_buf_to_bus_o,
    input wire logic data_buf_en_o,
    input wire logic scratch_memory_select_o,
    input wire logic diag_rom_select_o,
    input wire logic rom_two_select_o,
    input wire logic translator_select_o,
    input wire logic mem_ctrl_select_o,
    input wire logic plugin_bus_select_o,
    input wire logic irq_ctrl_select_o,
    input wire logic instrument_bus_select_o,
    input wire logic char_gen_select_o,
    input wire logic rom_six_select_o,
    input wire logic rom_seven_select_o
);
    logic [10:0] sel;
    logic mem_sel;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    assign sel = {rom_seven_select_o, rom_six_select_o, char_gen_select_o, instrument_bus_select_o,
                  irq_ctrl_select_o, plugin_bus_select_o, mem_ctrl_select_o, translator_select_o,
                  rom_two_select_o, diag_rom_select_o, scratch_memory_select_o};
    assign mem_sel = scratch_memory_select_o | diag_rom_select_o | rom_two_select_o | rom_six_select_o
                   | rom_seven_select_o | plugin_bus_select_o;
    // Width counter: a repetition of 25 would be too costly to unroll
    always_comb begin
        next_hi_cnt = mid_cycle_pulse_o ? hi_cnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= next_hi_cnt;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_ONE_HOT: assert property ($onehot0(sel)) else $error("more than one select");
    AST_ADDR_BUF: assert property (addr_buf_en_o) else $error("address buffer off");
    AST_DIR: assert property (data_buf_to_bus_o == !write_low_o) else $error("direction mismatch");
    AST_NO_SEL_RST: assert property (!reset_out_low_o && !$past(reset_out_low_o) |-> sel == 11'h000)
        else $error("select during reset out");
    AST_ROM2: assert property (rom_two_select_o |-> sys_addr_o[14:12] == BLK_ROM2)
        else $error("rom two select off region");
    AST_RAM: assert property (scratch_memory_select_o |-> sys_addr_o[14:12] == BLK_RAM)
        else $error("ram select off region");
    AST_IRQ: assert property (irq_ctrl_select_o |-> sys_addr_o[14:10] == {BLK_PERI, SUB_IRQC})
        else $error("irq select off region");
    AST_TRI: assert property (mem_sel |-> !data_buf_en_o) else $error("buffer not tri-stated");
    AST_BUF_ON: assert property (sel == 11'h000 |-> data_buf_en_o) else $error("buffer off idle");
    AST_PULSE_W: assert property ($fell(mid_cycle_pulse_o) |-> hi_cnt == PULSE_WIDTH_CYC)
        else $error("strobe width wrong");
    COV_ROM2: cover property (rom_two_select_o);
    COV_IRQ: cover property (irq_ctrl_select_o);
    COV_PULSE: cover property ($rose(mid_cycle_pulse_o));
    COV_RST: cover property ($rose(reset_out_low_o));
endmodule : mbd_top_chk
bind mbd_top mbd_top_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) mbd_top_chk_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reset_out_low_o(reset_out_low_o), .sys_addr_o(sys_addr_o),
    .write_low_o(write_low_o), .mid_cycle_pulse_o(mid_cycle_pulse_o), .addr_buf_en_o(addr_buf_en_o),
    .data_buf_to_bus_o(data_buf_to_bus_o), .data_buf_en_o(data_buf_en_o),
    .scratch_memory_select_o(scratch_memory_select_o), .diag_rom_select_o(diag_rom_select_o),
    .rom_two_select_o(rom_two_select_o), .translator_select_o(translator_select_o),
    .mem_ctrl_select_o(mem_ctrl_select_o), .plugin_bus_select_o(plugin_bus_select_o),
    .irq_ctrl_select_o(irq_ctrl_select_o), .instrument_bus_select_o(instrument_bus_select_o),
    .char_gen_select_o(char_gen_select_o), .rom_six_select_o(rom_six_select_o),
    .rom_seven_select_o(rom_seven_select_o));
`default_nettype wire

// ===== verification/mbd_cpu_model.sv
// Purpose: Processor-side model driving address, read/write, valid flag and phase two
// Assumes: One bus cycle per start pulse, phase-two length set per cycle
// Notes: Released address lines flip every cycle so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module mbd_cpu_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [14:0] addr_i,
    input wire logic rw_i,
    input wire logic valid_i,
    input wire logic [7:0] e_len_i,
    output logic [14:0] addr_o,
    output logic rw_o,
    output logic valid_o,
    output logic e_o,
    output logic busy_o
);
    int cnt;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_o <= '0;
            rw_o <= 1'b1;
            valid_o <= 1'b0;
            e_o <= 1'b0;
            busy_o <= 1'b0;
            cnt <= 0;
        end else if (!busy_o) begin
            addr_o <= start_i ? addr_i : ~addr_o;
            if (start_i) begin
                rw_o <= rw_i;
                busy_o <= 1'b1;
                cnt <= 0;
            end
        end else begin
            cnt <= cnt + 1;
            if (cnt == 2) valid_o <= valid_i; // Valid flag only after address settles
            if (cnt == 4) e_o <= 1'b1;
            if (cnt == 4 + e_len_i) begin
                e_o <= 1'b0;
                valid_o <= 1'b0;
            end
            if (cnt == 8 + e_len_i) begin
                busy_o <= 1'b0;
                rw_o <= 1'b1;
            end
        end
    end
endmodule : mbd_cpu_model
`default_nettype wire

// ===== verification/tb_mpu_bus_decode_and_clock.sv
// Purpose: Self-checking bench for the bus glue
// Assumes: Reset delay shortened to 20 cycles
// Notes: Board clock is 25 system cycles, so the processor clock period is 75
`timescale 1ns/1ps
`default_nettype none
module tb_mpu_bus_decode_and_clock;
    import mbd_pkg::*;
    localparam int RST_CYC = 20;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, board_clk_i = 1'b0, power_good_i = 1'b0;
    logic start = 1'b0, req_rw = 1'b1, req_valid = 1'b0;
    logic [14:0] req_addr = '0, addr;
    logic [7:0] e_len = 8'h96;
    logic rw, valid, e, busy, cpu_clk_o, reset_out_low_o, write_low_o, mid_cycle_pulse_o, addr_buf_en_o;
    logic data_buf_to_bus_o, data_buf_en_o;
    logic [14:0] sys_addr_o;
    logic [10:0] sel;
    int n_errors = 0, comparisons = 0, cyc = 0, bcnt = 0, k;
    mbd_cpu_model mbd_cpu_model_inst (.clk_i(sys_clk_i), .nrst_i(nrst_i), .start_i(start), .addr_i(req_addr),
        .rw_i(req_rw), .valid_i(req_valid), .e_len_i(e_len), .addr_o(addr), .rw_o(rw), .valid_o(valid), .e_o(e),
        .busy_o(busy));
    mbd_top #(.RESET_DELAY_CYC(RST_CYC)) mbd_top_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .board_clk_i(board_clk_i), .power_good_i(power_good_i), .addr_i(addr), .rw_i(rw),
        .valid_address_flag_i(valid), .phase_two_i(e), .cpu_clk_o(cpu_clk_o), .reset_out_low_o(reset_out_low_o),
        .sys_addr_o(sys_addr_o), .write_low_o(write_low_o), .mid_cycle_pulse_o(mid_cycle_pulse_o),
        .addr_buf_en_o(addr_buf_en_o), .data_buf_to_bus_o(data_buf_to_bus_o), .data_buf_en_o(data_buf_en_o),
        .scratch_memory_select_o(sel[0]), .diag_rom_select_o(sel[1]), .rom_two_select_o(sel[2]),
        .translator_select_o(sel[3]), .mem_ctrl_select_o(sel[4]), .plugin_bus_select_o(sel[5]),
        .irq_ctrl_select_o(sel[6]), .instrument_bus_select_o(sel[7]), .char_gen_select_o(sel[8]),
        .rom_six_select_o(sel[9]), .rom_seven_select_o(sel[10]));
    always #2 sys_clk_i = ~sys_clk_i;
    // Board clock: 12 high, 13 low, 100 ns period
    always @(posedge sys_clk_i) begin
        cyc++;
        bcnt <= (bcnt == 24) ? 0 : bcnt + 1;
        board_clk_i <= (bcnt < 12);
        if (cyc == 60000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [10:0] exp_sel(input int a);
        int b;
        b = (a >> 12) & 7;
        return 11'h1 << ((b < 3) ? b : (b == 3) ? 3 + ((a >> 10) & 3) : b + 3);
    endfunction : exp_sel
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic xfer(input int a, input logic w_rw, input logic w_valid);
        int rise_at, hi;
        logic on;
        on = w_valid && (reset_out_low_o === 1'b1);
        @(posedge sys_clk_i);
        req_addr <= a[14:0];
        req_rw <= w_rw;
        req_valid <= w_valid;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        k = 0;
        // Valid flag rises during this wait, phase two not yet: no select may show
        while (e !== 1'b1 && k < 50) begin
            tick(1);
            chk(sel, 11'h0);
            k++;
        end
        rise_at = -1;
        hi = 0;
        for (int i = 0; i < e_len + 40; i++) begin
            tick(1);
            if (mid_cycle_pulse_o === 1'b1) begin
                hi++;
                if (rise_at < 0) rise_at = i;
            end
            if (i == 30) begin
                chk(sel, on ? exp_sel(a) : 11'h0);
                chk(data_buf_en_o, !(on && (((exp_sel(a) & 11'h627) != 0))));
                chk(write_low_o, w_rw);
                chk(data_buf_to_bus_o, !w_rw);
                chk(sys_addr_o, a[14:0]);
                chk(addr_buf_en_o, 1'b1);
            end
            if (i == e_len + 10) chk(sel, 11'h0);
        end
        chk(hi, PULSE_WIDTH_CYC);
        chk(rise_at >= PULSE_DELAY_CYC - 2 && rise_at <= PULSE_DELAY_CYC + 8, 1);
    endtask : xfer
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        int base [11] = '{'h0, 'h1000, 'h2000, 'h3000, 'h3400, 'h3800, 'h3c00, 'h4000, 'h5000, 'h6000, 'h7000};
        void'($urandom(32'h9d521bf1));
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        xfer(32'h2100, 1'b1, 1'b1);
        @(posedge sys_clk_i);
        power_good_i <= 1'b1;
        for (k = 0; k < RST_CYC + 40 && reset_out_low_o !== 1'b1; k++) tick(1);
        chk(k >= RST_CYC && k < RST_CYC + 40, 1);
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            foreach (base[j]) begin
                e_len <= ($urandom & 1) ? 8'h96 : 8'hc8;
                xfer(base[j] + ($urandom & 'h3ff), 1'($urandom & 1), 1'b1);
            end
        end
        xfer(32'h3c02, 1'b0, 1'b0);
        $display("test decode done");
        for (k = 0; k < 100 && cpu_clk_o !== 1'b0; k++) tick(1);
        for (k = 0; k < 100 && cpu_clk_o !== 1'b1; k++) tick(1);
        for (k = 0; k < 100 && cpu_clk_o === 1'b1; k++) tick(1);
        chk(k, 50);
        for (int i = 0; i < 100 && cpu_clk_o === 1'b0; i++) begin
            tick(1);
            k++;
        end
        chk(k, 75);
        $display("test divider done");
        @(posedge sys_clk_i);
        power_good_i <= 1'b0;
        tick(10);
        chk(reset_out_low_o, 1'b0);
        xfer(32'h7010, 1'b1, 1'b1);
        $display("test power loss done");
        wrap_up();
    end
endmodule : tb_mpu_bus_decode_and_clock
`default_nettype wire
